// ### src/gitc_pkg.sv
// Constants shared by the global interrupt and timer command block.
// Assumes an eight-channel serial controller with byte-wide registers.
package gitc_pkg;

    // ========================================================
    // Sizes
    localparam int NCH    = 8;
    localparam int CODE_W = 3;
    localparam int SRC_W  = NCH * CODE_W;

    // ========================================================
    // Register offsets
    localparam logic [7:0] OFS_PEND   = 8'h80;
    localparam logic [7:0] OFS_SRC_LO = 8'h81;
    localparam logic [7:0] OFS_SRC_MD = 8'h82;
    localparam logic [7:0] OFS_SRC_HI = 8'h83;
    localparam logic [7:0] OFS_TCTL   = 8'h84;

    // ========================================================
    // Reset values
    localparam logic [7:0]       PEND_RESET = 8'h00;
    localparam logic [SRC_W-1:0] SRC_RESET  = 24'h00_0000;
    localparam logic [3:0]       TCTL_RESET = 4'h0;
    localparam logic [7:0]       RD_RESET   = 8'h00;

    // ========================================================
    // Timer control field positions
    localparam int TCTL_CLK = 3;
    localparam int TCTL_FUN = 2;
    localparam int TCTL_RUN = 1;
    localparam int TCTL_IEN = 0;

    // ========================================================
    // Timer commands, low nibble of a write
    localparam logic [3:0] CMD_IRQ_ON  = 4'h1;
    localparam logic [3:0] CMD_IRQ_OFF = 4'h2;
    localparam logic [3:0] CMD_ONESHOT = 4'h3;
    localparam logic [3:0] CMD_RETRIG  = 4'h4;
    localparam logic [3:0] CMD_CLK_INT = 4'h5;
    localparam logic [3:0] CMD_CLK_EXT = 4'h6;
    localparam logic [3:0] CMD_START   = 4'h9;
    localparam logic [3:0] CMD_STOP    = 4'hA;
    localparam logic [3:0] CMD_RESTART = 4'hB;

    // ========================================================
    // Source codes
    localparam logic [2:0] SRC_NONE  = 3'h0;
    localparam logic [2:0] SRC_RX    = 3'h1;
    localparam logic [2:0] SRC_TOUT  = 3'h2;
    localparam logic [2:0] SRC_TX    = 3'h3;
    localparam logic [2:0] SRC_FLOW  = 3'h4;
    localparam logic [2:0] SRC_RSV5  = 3'h5;
    localparam logic [2:0] SRC_RSV6  = 3'h6;
    localparam logic [2:0] SRC_TIMER = 3'h7;

endpackage

// ### src/gitc_chan_enc.sv
// Per-channel priority encoder for the packed interrupt source code.
// Assumes its inputs are level interrupt requests of one channel.
`timescale 1ns/1ps
module gitc_chan_enc
    import gitc_pkg::*;
(
    input  wire logic       rx_event,
    input  wire logic       rx_timeout,
    input  wire logic       tx_ready,
    input  wire logic       flow_event,
    input  wire logic       wake,
    input  wire logic       timer_event,
    output logic [2:0]      code,
    output logic            pending
);

    // ========================================================
    // Encoding
    // Lowest priority number wins; wake alone gives code zero
    always_comb begin
        if (rx_event) begin
            code = SRC_RX;                             // [RULE_04] [RULE_13]
        end else if (rx_timeout) begin
            code = SRC_TOUT;                           // [RULE_04]
        end else if (tx_ready) begin
            code = SRC_TX;                             // [RULE_04]
        end else if (flow_event) begin
            code = SRC_FLOW;                           // [RULE_05]
        end else if (timer_event) begin
            code = SRC_TIMER;                          // [RULE_06]
        end else begin
            code = SRC_NONE;                           // [RULE_03]
        end
    end

    // Wake counts as pending even though its code reads zero
    assign pending = rx_event | rx_timeout | tx_ready | flow_event |
                     timer_event | wake;

endmodule // gitc_chan_enc

// ### src/gitc_top.sv
// Global interrupt gathering and timer command decode.
// Assumes channel requests and the bus are synchronous to core_clk.
//
// What this block does
// [RULE_01] A read-only byte shows one pending bit per channel 0 to 7.
// [RULE_02] Three read-only bytes pack a 3-bit code per channel, ch0 lowest.
// [RULE_03] A channel with nothing pending or only wake-up reads code 000.
// [RULE_04] Codes 001, 010, 011 mean receive, receive time-out, transmit.
// [RULE_05] Code 100 means modem, flow or special events; 101/110 never.
// [RULE_06] Timer expiry reads as code 111 in channel 0's field only.
// [RULE_07] Timer expiry stays set until the timer control byte is read.
// [RULE_08] Timer control resets to zero; upper nibble reads zero.
// [RULE_09] Commands 1 to 4 switch interrupt enable and one-shot/retrigger.
// [RULE_10] Commands 5 and 6 select internal or external count clock.
// [RULE_11] Reserved commands cause no timer action.
// [RULE_12] Commands 9, A, B start, stop and restart the timer.
// [RULE_13] With several sources pending the lowest number is shown.
`timescale 1ns/1ps
module gitc_top
    import gitc_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           reset,
    input  wire logic           ce,
    input  wire logic [7:0]     bus_addr,
    input  wire logic [7:0]     bus_wdata,
    input  wire logic           bus_wr,
    input  wire logic           bus_rd,
    output logic [7:0]          bus_rdata,
    input  wire logic [NCH-1:0] ch_rx_event,
    input  wire logic [NCH-1:0] ch_rx_timeout,
    input  wire logic [NCH-1:0] ch_tx_ready,
    input  wire logic [NCH-1:0] ch_flow_event,
    input  wire logic [NCH-1:0] ch_wake,
    input  wire logic           timer_expire,
    output logic                timer_ext_clk,
    output logic                timer_retrigger,
    output logic                timer_running,
    output logic                timer_irq_enable,
    output logic                timer_restart,
    output logic                timer_irq
);

    // ========================================================
    // State
    logic [7:0]       pend_q;
    logic [SRC_W-1:0] src_q;
    logic [3:0]       tctl_q;
    logic             tflag_q;
    logic             restart_q;
    logic [7:0]       rdata_q;

    logic [NCH-1:0]   pend_d;
    logic [SRC_W-1:0] src_d;
    logic [NCH-1:0]   tmr_vec;
    logic             wr_ctl;
    logic             rd_ctl;
    logic [3:0]       cmd;

    assign wr_ctl = bus_wr && (bus_addr == OFS_TCTL);
    assign rd_ctl = bus_rd && (bus_addr == OFS_TCTL);
    assign cmd    = bus_wdata[3:0];

    // Only channel 0 ever carries the timer source
    assign tmr_vec = {{(NCH-1){1'b0}}, tflag_q & tctl_q[TCTL_IEN]};

    // ========================================================
    // Per-channel encoders
    genvar k;
    generate
        for (k = 0; k < NCH; k++) begin : g_ch
            gitc_chan_enc u_enc (
                .rx_event    (ch_rx_event[k]),
                .rx_timeout  (ch_rx_timeout[k]),
                .tx_ready    (ch_tx_ready[k]),
                .flow_event  (ch_flow_event[k]),
                .wake        (ch_wake[k]),
                .timer_event (tmr_vec[k]),
                .code        (src_d[k*CODE_W +: CODE_W]),
                .pending     (pend_d[k])
            );
        end
    endgenerate

    // ========================================================
    // Status capture, one cycle behind the channel requests
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_q <= PEND_RESET;
            src_q  <= SRC_RESET;
        end else if (ce) begin
            pend_q <= pend_d;                                 // [RULE_01]
            src_q  <= src_d;                                  // [RULE_02]
        end
    end

    // ========================================================
    // Timer command decode; unknown codes fall to default
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tctl_q <= TCTL_RESET;                             // [RULE_08]
        end else if (ce && wr_ctl) begin
            case (cmd)
                CMD_IRQ_ON:  tctl_q[TCTL_IEN] <= 1'b1;        // [RULE_09]
                CMD_IRQ_OFF: tctl_q[TCTL_IEN] <= 1'b0;        // [RULE_09]
                CMD_ONESHOT: tctl_q[TCTL_FUN] <= 1'b0;        // [RULE_09]
                CMD_RETRIG:  tctl_q[TCTL_FUN] <= 1'b1;        // [RULE_09]
                CMD_CLK_INT: tctl_q[TCTL_CLK] <= 1'b0;        // [RULE_10]
                CMD_CLK_EXT: tctl_q[TCTL_CLK] <= 1'b1;        // [RULE_10]
                CMD_START:   tctl_q[TCTL_RUN] <= 1'b1;        // [RULE_12]
                CMD_STOP:    tctl_q[TCTL_RUN] <= 1'b0;        // [RULE_12]
                default:     tctl_q <= tctl_q;                // [RULE_11]
            endcase
        end
    end

    // Restart is a one-cycle strobe to the counting datapath
    always_ff @(posedge core_clk) begin
        if (reset) begin
            restart_q <= 1'b0;
        end else if (ce) begin
            restart_q <= wr_ctl && (cmd == CMD_RESTART);      // [RULE_12]
        end
    end

    // ========================================================
    // Expiry flag; a new expiry beats the clearing read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tflag_q <= 1'b0;
        end else if (ce) begin
            if (timer_expire && tctl_q[TCTL_IEN]) begin
                tflag_q <= 1'b1;                              // [RULE_07]
            end else if (rd_ctl) begin
                tflag_q <= 1'b0;                              // [RULE_07]
            end
        end
    end

    // ========================================================
    // Read port, data valid the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= RD_RESET;
        end else if (ce && bus_rd) begin
            case (bus_addr)
                OFS_PEND:   rdata_q <= pend_q;                // [RULE_01]
                OFS_SRC_LO: rdata_q <= src_q[7:0];            // [RULE_02]
                OFS_SRC_MD: rdata_q <= src_q[15:8];           // [RULE_02]
                OFS_SRC_HI: rdata_q <= src_q[23:16];          // [RULE_02]
                OFS_TCTL:   rdata_q <= {4'h0, tctl_q};        // [RULE_08]
                default:    rdata_q <= RD_RESET;
            endcase
        end
    end

    // ========================================================
    // Outputs, all from flops
    assign bus_rdata        = rdata_q;
    assign timer_ext_clk    = tctl_q[TCTL_CLK];
    assign timer_retrigger  = tctl_q[TCTL_FUN];
    assign timer_running    = tctl_q[TCTL_RUN];
    assign timer_irq_enable = tctl_q[TCTL_IEN];
    assign timer_restart    = restart_q;
    assign timer_irq        = tflag_q;

    // ========================================================
    // Checks
    logic [NCH-1:0] any_src;
    logic           bad_code;
    logic           tmr_off0;
    always_comb begin
        bad_code = 1'b0;
        tmr_off0 = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            any_src[i] = ch_rx_event[i] | ch_rx_timeout[i] |
                         ch_tx_ready[i] | ch_flow_event[i];
            if (src_q[i*CODE_W +: CODE_W] == SRC_RSV5 ||
                src_q[i*CODE_W +: CODE_W] == SRC_RSV6) begin
                bad_code = 1'b1;
            end
            if (i > 0 && src_q[i*CODE_W +: CODE_W] == SRC_TIMER) begin
                tmr_off0 = 1'b1;
            end
        end
    end

    property p_pend;
        @(posedge core_clk) disable iff (reset)
        ce |=> pend_q == $past(pend_d);
    endproperty
    a_pend: assert property (p_pend)                          // [RULE_01]
        else $error("pending byte does not follow channels");

    property p_zero;
        @(posedge core_clk) disable iff (reset)
        ce && !any_src[3] |=> src_q[11:9] == SRC_NONE;
    endproperty
    a_zero: assert property (p_zero)                          // [RULE_03]
        else $error("idle channel code not zero");

    property p_rx_wins;
        @(posedge core_clk) disable iff (reset)
        ce && ch_rx_event[5] |=> src_q[17:15] == SRC_RX;
    endproperty
    a_rx_wins: assert property (p_rx_wins)                    // [RULE_13]
        else $error("receive source not shown first");

    property p_flow;
        @(posedge core_clk) disable iff (reset)
        ce && ch_flow_event[2] && !ch_tx_ready[2] &&
        !ch_rx_timeout[2] && !ch_rx_event[2]
        |=> src_q[8:6] == SRC_FLOW;
    endproperty
    a_flow: assert property (p_flow)                          // [RULE_05]
        else $error("flow event code wrong");

    property p_no_rsv;
        @(posedge core_clk) disable iff (reset)
        !bad_code;
    endproperty
    a_no_rsv: assert property (p_no_rsv)                      // [RULE_05]
        else $error("reserved source code produced");

    property p_tmr_ch0;
        @(posedge core_clk) disable iff (reset)
        !tmr_off0;
    endproperty
    a_tmr_ch0: assert property (p_tmr_ch0)                    // [RULE_06]
        else $error("timer code outside channel 0");

    property p_hold;
        @(posedge core_clk) disable iff (reset)
        tflag_q && !(ce && rd_ctl) |=> tflag_q;
    endproperty
    a_hold: assert property (p_hold)                          // [RULE_07]
        else $error("timer flag dropped without read");

    property p_clear;
        @(posedge core_clk) disable iff (reset)
        ce && rd_ctl && !timer_expire |=> !tflag_q;
    endproperty
    a_clear: assert property (p_clear)                        // [RULE_07]
        else $error("timer flag not cleared by read");

    property p_ien;
        @(posedge core_clk) disable iff (reset)
        ce && wr_ctl && cmd == CMD_IRQ_ON |=> timer_irq_enable [*1];
    endproperty
    a_ien: assert property (p_ien)                            // [RULE_09]
        else $error("enable command ignored");

    property p_rsv_cmd;
        @(posedge core_clk) disable iff (reset)
        ce && wr_ctl && (cmd == 4'h7 || cmd == 4'h8 || cmd >= 4'hC)
        |=> $stable(tctl_q) && !timer_restart;
    endproperty
    a_rsv_cmd: assert property (p_rsv_cmd)                    // [RULE_11]
        else $error("reserved command changed timer");

    property p_start;
        @(posedge core_clk) disable iff (reset)
        ce && wr_ctl && cmd == CMD_START |=> timer_running;
    endproperty
    a_start: assert property (p_start)                        // [RULE_12]
        else $error("start command ignored");

endmodule // gitc_top

// ### bench/gitc_host.sv
// Host processor model that owns the register bus of the block.
// Assumes core_clk runs freely; it drives only at falling edges.
`timescale 1ns/1ps
module gitc_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] bus_rdata,
    output logic            ce,
    output logic [7:0]      bus_addr,
    output logic [7:0]      bus_wdata,
    output logic            bus_wr,
    output logic            bus_rd
);
    // ========================================================
    // Idle bus
    // Idle write data is never left at the last value written
    initial begin
        ce        = 1'b1;
        bus_addr  = 8'h00;
        bus_wdata = 8'hA5;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
    end

    // ========================================================
    // Bus cycles
    // Reserved commands go out only when the bench asks for them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        bus_addr  = a;
        bus_wdata = d;
        bus_wr    = 1'b1;
        @(negedge core_clk);
        bus_wr    = 1'b0;
        bus_wdata = ~d;
    endtask

    // Read of the timer control byte is how expiry is acknowledged
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        bus_addr = a;
        bus_rd   = 1'b1;
        @(negedge core_clk);
        bus_rd   = 1'b0;
        d        = bus_rdata;
    endtask
endmodule // gitc_host

// ### bench/global_irq_and_timer_cmd_test.sv
// Self-checking bench for the interrupt gathering and timer commands.
// Assumes gitc_top and the gitc_host model; 25 ns clock.
`timescale 1ns/1ps
module global_irq_and_timer_cmd_test;
    import gitc_pkg::*;
    logic           core_clk = 1'b0;
    logic           reset    = 1'b1;
    logic           ce;
    logic [7:0]     bus_addr, bus_wdata, bus_rdata, d;
    logic           bus_wr, bus_rd;
    logic [NCH-1:0] rx = '0, to = '0, tx = '0, fl = '0, wk = '0;
    logic           tex = 1'b0;
    logic           t_clk, t_ret, t_run, t_ien, t_rst, t_irq;
    logic [3:0]     m_ctl = 4'h0;
    logic           m_flag = 1'b0;
    int             miscompares = 0, compares = 0, cycles = 0;

    gitc_top DUT (.core_clk(core_clk), .reset(reset), .ce(ce),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ch_rx_event(rx),
        .ch_rx_timeout(to), .ch_tx_ready(tx), .ch_flow_event(fl),
        .ch_wake(wk), .timer_expire(tex), .timer_ext_clk(t_clk),
        .timer_retrigger(t_ret), .timer_running(t_run),
        .timer_irq_enable(t_ien), .timer_restart(t_rst),
        .timer_irq(t_irq));
    gitc_host host (.core_clk(core_clk), .bus_rdata(bus_rdata), .ce(ce),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd));

    // ========================================================
    // Clock and hang guard
    always #12.5 core_clk = ~core_clk;
    // Generous ceiling: the whole run needs under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // ========================================================
    // Reference model
    // Lowest code number wins; timer shows only in channel 0
    function automatic logic [7:0] model_rd(input logic [7:0] a);
        logic [SRC_W-1:0] s;
        logic [7:0]       p;
        logic [2:0]       c;
        for (int k = 0; k < NCH; k++) begin
            c = rx[k] ? 3'h1 : to[k] ? 3'h2 : tx[k] ? 3'h3 : fl[k] ? 3'h4
              : (k == 0 && m_flag && m_ctl[0]) ? 3'h7 : 3'h0;
            s[3*k +: 3] = c;
            p[k] = (c != 3'h0) || wk[k];
        end
        case (a)
            8'h80: return p;
            8'h81: return s[7:0];
            8'h82: return s[15:8];
            8'h83: return s[23:16];
            8'h84: return {4'h0, m_ctl};
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Expectation is taken before the read, which may clear expiry
    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] e;
        e = model_rd(a);
        host.rd(a, d);
        if (a == 8'h84) m_flag = 1'b0;
        chk(d, e);
    endtask

    // Upper nibble is random: it must not disturb the decode
    task automatic cmd(input logic [3:0] c);
        host.wr(8'h84, {4'($urandom_range(15)), c});
        chk({7'h0, t_rst}, {7'h0, c == 4'hB});
        case (c)
            4'h1: m_ctl[0] = 1'b1;
            4'h2: m_ctl[0] = 1'b0;
            4'h3: m_ctl[2] = 1'b0;
            4'h4: m_ctl[2] = 1'b1;
            4'h5: m_ctl[3] = 1'b0;
            4'h6: m_ctl[3] = 1'b1;
            4'h9: m_ctl[1] = 1'b1;
            4'hA: m_ctl[1] = 1'b0;
            default: ;
        endcase
        chk({4'h0, t_clk, t_ret, t_run, t_ien}, {4'h0, m_ctl});
        rd_chk(8'h84);
    endtask

    task automatic pulse_expiry();
        @(negedge core_clk);
        tex = 1'b1;
        @(negedge core_clk);
        tex = 1'b0;
        m_flag = m_ctl[0];
    endtask

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ========================================================
    // Test sequence
    initial begin
        void'($urandom(32'hfaeb_3632));
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        for (int a = 8'h80; a <= 8'h85; a++) rd_chk(8'(a));
        $display("test reset values done");
        for (int i = 0; i < 40; i++) begin
            rx = 8'($urandom & $urandom);
            to = 8'($urandom & $urandom);
            tx = 8'($urandom & $urandom);
            fl = 8'($urandom & $urandom);
            wk = 8'($urandom);
            repeat (2) @(negedge core_clk);
            for (int a = 8'h80; a <= 8'h83; a++)
                rd_chk(8'(a));
            // Random address around the map, mapped bytes included
            rd_chk(8'($urandom_range(8'h87, 8'h78)));
        end
        $display("test channel codes done");
        for (int c = 0; c < 16; c++) cmd(4'(c));
        for (int c = 15; c >= 0; c--) cmd(4'(c));
        // Timer is running here, so a frozen stop must leave it running
        host.ce = 1'b0;
        host.wr(8'h84, 8'h0A);
        host.ce = 1'b1;
        rd_chk(8'h84);
        $display("test timer commands done");
        {rx, to, tx, fl, wk} = '0;
        cmd(4'h1);
        pulse_expiry();
        repeat (3) @(negedge core_clk);
        chk({7'h0, t_irq}, 8'h01);
        rd_chk(8'h81);
        rd_chk(8'h80);
        rx[0] = 1'b1;
        wk[3] = 1'b1;
        repeat (2) @(negedge core_clk);
        rd_chk(8'h81);
        rd_chk(8'h80);
        rd_chk(8'h82);
        rx[0] = 1'b0;
        rd_chk(8'h84);
        chk({7'h0, t_irq}, 8'h00);
        rd_chk(8'h81);
        cmd(4'h2);
        pulse_expiry();
        chk({7'h0, t_irq}, 8'h00);
        rd_chk(8'h81);
        $display("test timer expiry done");
        end_sim();
    end
endmodule // global_irq_and_timer_cmd_test
